// ===== core/sewa_core.v
// serial word-access nonvolatile memory: pin engine and register slave
//
// Overview of operation
// - three mode lines select one of seven functions
// - standby keeps registers, line floats
// - erase clears addressed word to all zeros
// - accept address shifts line into address
// - read copies addressed word into data register
// - shift out drives line, one bit per clock
// - write ORs data register into addressed word
// - accept data shifts line, address untouched
// - line direction follows mode, floats otherwise
// - output bit valid within 20 us
// - fifty words of fourteen bits, each alterable
`timescale 1ns/100ps
`default_nettype none
`include "sewa_map.vh"

module sewa_core #(
  parameter PROG_CYC = `SEWA_PROG_CYC
) (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // device pins
  input  wire        ser_clk_pin,
  input  wire [2:0]  mode_pin,
  input  wire        sio_in,
  output reg         sio_out,
  output reg         sio_oe,
  // axi4-lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ========================================================
  // pin synchronisers
  reg        sclk_s1_reg;
  reg        sclk_s2_reg;
  reg        sclk_d_reg;
  reg  [2:0] mode_s1_reg;
  reg  [2:0] mode_s2_reg;
  reg  [2:0] mode_d_reg;
  reg        sio_s1_reg;
  reg        sio_s2_reg;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_s1_reg <= 1'b1;
      sclk_s2_reg <= 1'b1;
      sclk_d_reg  <= 1'b1;
      mode_s1_reg <= `SEWA_M_STANDBY;
      mode_s2_reg <= `SEWA_M_STANDBY;
      mode_d_reg  <= `SEWA_M_STANDBY;
      sio_s1_reg  <= 1'b0;
      sio_s2_reg  <= 1'b0;
    end else begin
      sclk_s1_reg <= ser_clk_pin;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_d_reg  <= sclk_s2_reg;
      mode_s1_reg <= mode_pin;
      mode_s2_reg <= mode_s1_reg;
      mode_d_reg  <= mode_s2_reg;
      sio_s1_reg  <= sio_in;
      sio_s2_reg  <= sio_s1_reg;
    end
  end

  // inputs are stable through the low phase, so the falling edge is the safe sample point
  wire sclk_fall = sclk_d_reg & ~sclk_s2_reg;
  wire sclk_rise = ~sclk_d_reg & sclk_s2_reg;
  wire mode_new  = (mode_s2_reg != mode_d_reg);
  wire [2:0] mode = mode_s2_reg;

  // ========================================================
  // storage array, not reset: it models nonvolatile cells
  reg [`SEWA_WORD_W-1:0] mem [0:`SEWA_WORDS-1];

  // ========================================================
  // address digits and decode
  reg  [`SEWA_ADDR_BITS-1:0] addr_sr_reg;
  reg  [3:0]                 tens;
  reg  [3:0]                 units;
  reg  [4:0]                 tens_hits;
  reg  [4:0]                 units_hits;
  reg  [`SEWA_IDX_W-1:0]     word_idx;
  wire                       addr_valid;
  integer                    k;

  always @* begin
    tens       = 4'h0;
    units      = 4'h0;
    tens_hits  = 5'h00;
    units_hits = 5'h00;
    for (k = 0; k < `SEWA_DIGIT_W; k = k + 1) begin
      if (addr_sr_reg[`SEWA_DIGIT_W + k]) begin
        tens      = k[3:0];
        tens_hits = tens_hits + 5'h01;
      end
      if (addr_sr_reg[k]) begin
        units      = k[3:0];
        units_hits = units_hits + 5'h01;
      end
    end
    word_idx = {2'h0, tens} * 6'h0A + {2'h0, units};
  end

  // a tens digit of 6 or more can wrap the 6-bit index back into range, so tens above 4 is refused here
  assign addr_valid = (tens_hits == 5'h01) && (units_hits == 5'h01) &&
                      (tens < 4'h5) && (word_idx < `SEWA_WORDS);

  // ========================================================
  // control register from software
  reg        wp_reg;
  localparam [31:0] CTRL_RST = `SEWA_CTRL_RESET;

  // ========================================================
  // program sequencer for erase and write
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_PROG = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  reg  [2:0]              st_reg;
  reg  [2:0]              st_next;
  reg  [17:0]             cnt_reg;
  reg                     done_reg;
  reg  [`SEWA_WORD_W-1:0] data_reg;
  reg  [`SEWA_IDX_W-1:0]  prog_idx_reg;

  wire prog_mode = (mode == `SEWA_M_ERASE) || (mode == `SEWA_M_WRITE);
  wire prog_end  = (cnt_reg == PROG_CYC - 1);

  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (prog_mode && mode_new && addr_valid && !wp_reg) begin
          st_next = ST_PROG;
        end
      end
      ST_PROG: begin
        // leaving the mode early abandons the cell update
        if (!prog_mode || mode_new) begin
          st_next = ST_IDLE;
        end else if (prog_end) begin
          st_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!prog_mode || mode_new) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg       <= ST_IDLE;
      cnt_reg      <= 18'h00000;
      done_reg     <= 1'b0;
      prog_idx_reg <= 6'h00;
    end else begin
      st_reg <= st_next;
      if (st_reg == ST_IDLE) begin
        cnt_reg      <= 18'h00000;
        prog_idx_reg <= word_idx;
      end else if (st_reg == ST_PROG) begin
        cnt_reg <= cnt_reg + 18'h00001;
      end
      if (st_reg == ST_PROG && st_next == ST_DONE) begin
        done_reg <= 1'b1;
      end else if (st_reg == ST_IDLE && st_next == ST_PROG) begin
        done_reg <= 1'b0;
      end
    end
  end

  // cell update after the minimum hold time
  always @(posedge clk) begin
    if (st_reg == ST_PROG && prog_end && prog_mode && !mode_new) begin
      if (mode == `SEWA_M_ERASE) begin
        mem[prog_idx_reg] <= {`SEWA_WORD_W{1'b0}};
      end else begin
        // write can only raise bits, which is why erase must come first
        mem[prog_idx_reg] <= mem[prog_idx_reg] | data_reg;
      end
    end
  end

  // ========================================================
  // address and data shift registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_sr_reg <= {`SEWA_ADDR_BITS{1'b0}};
      data_reg    <= {`SEWA_WORD_W{1'b0}};
    end else begin
      case (mode)
        `SEWA_M_ACC_ADDR: begin
          if (sclk_fall) begin
            addr_sr_reg <= {addr_sr_reg[`SEWA_ADDR_BITS-2:0], sio_s2_reg};
          end
        end
        `SEWA_M_ACC_DATA: begin
          if (sclk_fall) begin
            data_reg <= {data_reg[`SEWA_WORD_W-2:0], sio_s2_reg};
          end
        end
        `SEWA_M_READ: begin
          if (mode_new && addr_valid) begin
            data_reg <= mem[word_idx];
          end
        end
        `SEWA_M_SHIFT_OUT: begin
          if (sclk_rise && !mode_new) begin
            data_reg <= {data_reg[`SEWA_WORD_W-2:0], 1'b0};
          end
        end
        default: begin
          // standby, erase, write and the unused code hold both registers
          addr_sr_reg <= addr_sr_reg;
        end
      endcase
    end
  end

  // ========================================================
  // serial line driver; a few cycles of latency, far inside 20 us
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sio_oe  <= 1'b0;
      sio_out <= 1'b0;
    end else begin
      sio_oe  <= (mode == `SEWA_M_SHIFT_OUT);
      sio_out <= data_reg[`SEWA_WORD_W-1];
    end
  end

  // ========================================================
  // axi4-lite write channel
  reg        aw_held_reg;
  reg        w_held_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;

  wire wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= 12'h000;
      wdata_reg    <= 32'h00000000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      wp_reg       <= CTRL_RST[`SEWA_CTRL_WP];
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_reg == `SEWA_REG_CTRL) begin
          s_axi_bresp <= 2'h0;
          if (wstrb_reg[0]) begin
            wp_reg <= wdata_reg[`SEWA_CTRL_WP];
          end
        end else if (awaddr_reg == `SEWA_REG_STATUS || awaddr_reg == `SEWA_REG_ADDR ||
                     awaddr_reg == `SEWA_REG_DATA) begin
          s_axi_bresp <= 2'h0;
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================================
  // axi4-lite read channel
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          `SEWA_REG_CTRL: begin
            s_axi_rdata <= {31'h00000000, wp_reg};
          end
          `SEWA_REG_STATUS: begin
            s_axi_rdata <= {25'h0000000, done_reg, sio_oe, addr_valid,
                            (st_reg == ST_PROG), mode};
          end
          `SEWA_REG_ADDR: begin
            s_axi_rdata <= {6'h00, addr_sr_reg, word_idx};
          end
          `SEWA_REG_DATA: begin
            s_axi_rdata <= {18'h00000, data_reg};
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // sewa_core

`default_nettype wire

// ===== core/sewa_map.vh
// constants for the serial word-access nonvolatile memory core
`ifndef SEWA_MAP_VH
`define SEWA_MAP_VH

// ==========================================================
// organisation
`define SEWA_WORDS        50
`define SEWA_WORD_W       14
`define SEWA_DIGIT_W      10
`define SEWA_ADDR_BITS    20
`define SEWA_IDX_W        6

// ==========================================================
// mode codes {c1,c2,c3}
`define SEWA_M_STANDBY    3'h7
`define SEWA_M_UNUSED     3'h6
`define SEWA_M_ERASE      3'h5
`define SEWA_M_ACC_ADDR   3'h4
`define SEWA_M_READ       3'h3
`define SEWA_M_SHIFT_OUT  3'h2
`define SEWA_M_WRITE      3'h1
`define SEWA_M_ACC_DATA   3'h0

// ==========================================================
// timing
`define SEWA_CLK_KHZ      10000
`define SEWA_PROG_MIN_MS  16
`define SEWA_PROG_CYC     (`SEWA_PROG_MIN_MS * `SEWA_CLK_KHZ)

// ==========================================================
// register map (byte addresses)
`define SEWA_REG_CTRL     12'h000
`define SEWA_REG_STATUS   12'h004
`define SEWA_REG_ADDR     12'h008
`define SEWA_REG_DATA     12'h00C

// field positions
`define SEWA_CTRL_WP      0
`define SEWA_ST_BUSY      3
`define SEWA_ST_AVALID    4
`define SEWA_ST_OE        5
`define SEWA_ST_DONE      6
`define SEWA_CTRL_RESET   32'h00000000

`endif

// ===== tb/sewa_checker.sv
// concurrent checks on the pins and register port of the memory core
`timescale 1ns/100ps
`default_nettype none
`include "sewa_map.vh"
module sewa_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // device pins
  input wire logic        ser_clk_pin,
  input wire logic [2:0]  mode_pin,
  input wire logic        sio_out,
  input wire logic        sio_oe,
  // register port
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ========================================
  // serial line
  sequence s_quiet;
    $stable(ser_clk_pin)[*8];
  endsequence
  sequence s_enter;
    mode_pin == `SEWA_M_SHIFT_OUT && $past(mode_pin) != `SEWA_M_SHIFT_OUT;
  endsequence
  property p_float;
    (mode_pin != `SEWA_M_SHIFT_OUT)[*8] |-> !sio_oe;
  endproperty
  a_float: assert property (p_float) else $error("line driven outside shift mode");
  property p_drive;
    (mode_pin == `SEWA_M_SHIFT_OUT)[*8] |-> sio_oe;
  endproperty
  a_drive: assert property (p_drive) else $error("line not driven in shift mode");
  property p_first;
    s_enter |-> ##[1:200] (sio_oe || mode_pin != `SEWA_M_SHIFT_OUT);
  endproperty
  a_first: assert property (p_first) else $error("first bit late");
  property p_hold;
    s_quiet ##0 (sio_oe && $past(sio_oe)) |-> $stable(sio_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved without clock rise");
  // ========================================
  // register port
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("write response late");
  property p_r_ans;
    s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
endmodule // sewa_checker
`default_nettype wire

// ===== tb/sewa_ctrl_model.sv
// controller model: mode lines, serial clock and its side of the data line
`timescale 1ns/100ps
`default_nettype none
module sewa_ctrl_model (
  // device pins
  output var logic       ser_clk_pin,
  output var logic [2:0] mode_pin,
  output var logic       sio_in,
  input  wire logic      sio_out,
  input  wire logic      sio_oe
);
  logic drv_en;
  logic drv_val;
  // a floating line shows the inverse, so stale data never passes for good
  always_comb sio_in = sio_oe ? sio_out : (drv_en ? drv_val : ~drv_val);
  initial begin
    ser_clk_pin = 1'b1; // rests high in standby
    mode_pin = 3'h7;
    drv_en = 1'b0;
    drv_val = 1'b0;
  end
  // one 70 us period, 50 percent duty; inputs move only while high
  task automatic bit_cycle(input logic b, output logic s);
    drv_val = b;
    #20000 s = sio_in; // after the output delay
    #15000 ser_clk_pin = 1'b0;
    #35000 ser_clk_pin = 1'b1;
  endtask
  // code 6 is never offered
  task automatic set_mode(input logic [2:0] m, input logic en);
    mode_pin = m;
    drv_en = en;
  endtask
  // program hold scaled down with the shortened program count
  task automatic hold();
    logic s;
    bit_cycle(1'b0, s);
    bit_cycle(1'b0, s);
  endtask
  task automatic send_addr(input int tens, input int units);
    logic s;
    for (int p = 9; p >= 0; p--) bit_cycle(p == tens, s); // one-hot, value 9 first
    for (int p = 9; p >= 0; p--) bit_cycle(p == units, s);
  endtask
  task automatic send_data(input logic [13:0] v);
    logic s;
    for (int i = 13; i >= 0; i--) bit_cycle(v[i], s);
  endtask
  task automatic recv(output logic [13:0] v);
    for (int i = 13; i >= 0; i--) bit_cycle(1'b0, v[i]);
  endtask
endmodule // sewa_ctrl_model
`default_nettype wire

// ===== tb/tb_top.sv
// testbench top: register master, scenarios and verdict
`timescale 1ns/100ps
`default_nettype none
`include "sewa_map.vh"
module tb_top;
  logic        clk, sys_rst, ser_clk, sio_in, sio_out, sio_oe;
  logic [2:0]  mode;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int          num_errors, checked;
  sewa_core #(.PROG_CYC(20)) i_sewa_core (.clk(clk), .sys_rst(sys_rst), .ser_clk_pin(ser_clk),
    .mode_pin(mode), .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  sewa_ctrl_model m (.ser_clk_pin(ser_clk), .mode_pin(mode), .sio_in(sio_in), .sio_out(sio_out),
    .sio_oe(sio_oe));
  // ========================================
  // register master and compare
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      r = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while (!bh);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ah = arvalid & arready;
      rh = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
    end while (!rh);
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] msk, input logic [31:0] exp, input string w);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    axi_rd(a, d, r);
    @(negedge clk);
    check(w, exp, d & msk);
  endtask
  // ========================================
  // scenarios
  task automatic t_regs();
    logic [1:0]  r;
    logic [31:0] d;
    rd_chk(`SEWA_REG_CTRL, 32'hFFFFFFFF, `SEWA_CTRL_RESET, "ctrl reset");
    @(posedge clk);
    axi_wr(12'h010, 32'h00000001, r);
    check("unmapped bresp", 32'h00000002, {30'h0, r});
    @(posedge clk);
    axi_rd(12'h010, d, r);
    check("unmapped rresp", 32'h00000002, {30'h0, r});
    check("unmapped rdata", 32'h00000000, d);
    @(posedge clk);
    axi_wr(`SEWA_REG_CTRL, 32'h00000001, r);
    rd_chk(`SEWA_REG_CTRL, 32'hFFFFFFFF, 32'h00000001, "ctrl set");
    @(posedge clk);
    axi_wr(`SEWA_REG_CTRL, 32'h00000000, r);
  endtask
  task automatic t_program();
    logic [13:0] v;
    m.set_mode(`SEWA_M_ACC_ADDR, 1'b1);
    m.send_addr(4, 9);
    rd_chk(`SEWA_REG_ADDR, 32'h03FFFFFF, {6'h0, 20'h04200, 6'd49}, "address");
    m.set_mode(`SEWA_M_ERASE, 1'b0); // erase ahead of the write
    m.hold();
    rd_chk(`SEWA_REG_STATUS, 32'h00000047, 32'h00000045, "erase status");
    m.set_mode(`SEWA_M_ACC_DATA, 1'b1);
    m.send_data(14'h2A5B);
    rd_chk(`SEWA_REG_DATA, 32'h00003FFF, 32'h00002A5B, "data in");
    rd_chk(`SEWA_REG_ADDR, 32'h0000003F, 32'h00000031, "address kept");
    m.set_mode(`SEWA_M_WRITE, 1'b0);
    m.hold();
    m.set_mode(`SEWA_M_STANDBY, 1'b0);
    m.hold();
    rd_chk(`SEWA_REG_DATA, 32'h00003FFF, 32'h00002A5B, "standby data");
    m.set_mode(`SEWA_M_ACC_DATA, 1'b1);
    m.send_data(14'h3FFF); // spoil the data register so the read must refetch
    m.set_mode(`SEWA_M_READ, 1'b0);
    m.hold();
    rd_chk(`SEWA_REG_DATA, 32'h00003FFF, 32'h00002A5B, "read word");
    m.set_mode(`SEWA_M_SHIFT_OUT, 1'b0);
    m.recv(v);
    check("shift out", 32'h00002A5B, {18'h0, v});
  endtask
  task automatic t_erase();
    logic [13:0] v;
    logic [1:0]  r;
    // a protected erase must leave the stored word alone
    @(posedge clk);
    axi_wr(`SEWA_REG_CTRL, 32'h00000001, r);
    @(negedge clk);
    m.set_mode(`SEWA_M_ERASE, 1'b0);
    m.hold();
    m.set_mode(`SEWA_M_READ, 1'b0);
    m.hold();
    m.set_mode(`SEWA_M_SHIFT_OUT, 1'b0);
    m.recv(v);
    check("protected word", 32'h00002A5B, {18'h0, v});
    @(posedge clk);
    axi_wr(`SEWA_REG_CTRL, 32'h00000000, r);
    @(negedge clk);
    m.set_mode(`SEWA_M_ERASE, 1'b0);
    m.hold();
    m.set_mode(`SEWA_M_READ, 1'b0);
    m.hold();
    m.set_mode(`SEWA_M_SHIFT_OUT, 1'b0);
    m.recv(v);
    check("erased word", 32'h00000000, {18'h0, v});
    m.set_mode(`SEWA_M_STANDBY, 1'b0);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ========================================
  // clock, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    sys_rst = 1'b1;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    @(negedge clk);
    t_program();
    t_erase();
    give_verdict();
  end
  // full run is near 7.4 ms of serial traffic
  initial begin
    #8000000;
    num_errors++;
    give_verdict();
  end
endmodule // tb_top
bind sewa_core sewa_checker i_sewa_checker (.clk(clk), .sys_rst(sys_rst), .ser_clk_pin(ser_clk_pin),
  .mode_pin(mode_pin), .sio_out(sio_out), .sio_oe(sio_oe), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
`default_nettype wire
